// >>> amrs_holdoff.sv
`timescale 1ns/10ps
module amrs_holdoff #(
  parameter logic [31:0] TIMEOUT_CYC = amrs_pkg::HOLDOFF_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Serial line, high while a start or zero bit is on it
  input wire logic i_line_active,
  // Alarm discrete, high once the keep-alive is lost
  output logic o_alarm
);

  typedef struct packed {
    logic [31:0] count;
    logic alarm;
  } amrs_hold_t;

  amrs_hold_t st;
  amrs_hold_t next_st;

  always_comb
  begin
    next_st = st;
    // Any character, whatever its symbol, restarts the timeout
    if (i_line_active)
    begin
      next_st.count = 32'h0000_0000;
      next_st.alarm = 1'b0;
    end
    else if (!st.alarm)
    begin
      // Counter parks on alarm, like the stopped oscillator
      if (st.count >= TIMEOUT_CYC - 32'h0000_0001)
      begin
        next_st.alarm = 1'b1;
      end
      else
      begin
        next_st.count = st.count + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_alarm = st.alarm;

endmodule // amrs_holdoff

// >>> amrs_pc_model.sv
`timescale 1ns/10ps
module amrs_pc_model (
  // Clock
  input wire logic i_clk,
  // Request message
  output logic o_req_valid,
  output logic o_req_is_cmd,
  output logic [5:0] o_req_addr,
  output logic [3:0] o_req_cmd
);
  initial
  begin
    o_req_valid = 1'b0;
    o_req_is_cmd = 1'b0;
    o_req_addr = 6'h00;
    o_req_cmd = 4'h0;
  end
  // One-cycle request; fields scrambled afterwards as a released bus would be
  task automatic send(input logic c, input logic [5:0] a, input logic [3:0] d);
    o_req_valid <= 1'b1;
    o_req_is_cmd <= c;
    o_req_addr <= a;
    o_req_cmd <= d;
    @(posedge i_clk);
    o_req_valid <= 1'b0;
    o_req_is_cmd <= ~c;
    o_req_addr <= ~a;
    o_req_cmd <= ~d;
    // Let an edge pass so back-to-back sends never assign twice in one step
    @(posedge i_clk);
  endtask
endmodule // amrs_pc_model

// >>> amrs_pkg.sv
package amrs_pkg;

  // APB register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_UNIT = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;

  // CTRL fields
  localparam int CTRL_CHAN_LSB = 0;
  localparam int CTRL_CHAN_W = 3;
  localparam int CTRL_SEL_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // STATUS fields
  localparam int STAT_MON_LSB = 0;
  localparam int STAT_DISC_LSB = 8;
  localparam int STAT_ALARM_LSB = 13;
  localparam int STAT_SEL_BIT = 16;
  localparam int STAT_CHAN_LSB = 17;

  // UNIT fields
  localparam int UNIT_ADDR_LSB = 0;
  localparam int UNIT_MATCH_BIT = 8;
  localparam int UNIT_CAUGHT_BIT = 9;

  // COUNT fields
  localparam int COUNT_SEEN_LSB = 0;
  localparam int COUNT_TAKEN_LSB = 16;

  // Widths of the parallel groups
  localparam int CMD_W = 4;
  localparam int MON_W = 8;
  localparam int ADDR_W = 6;
  localparam int ADDR_USED_W = 5;
  localparam int LEVEL_DISC_W = 5;
  localparam int HOLDOFF_N = 2;
  localparam int CHAN_POPULATED = 2;

  // Expected strapped unit address
  localparam logic [5:0] UNIT_ADDR_EXPECT = 6'h01;

  // Holdoff watchdog timing
  localparam longint unsigned CLK_HZ = 20_000_000;
  localparam longint unsigned HOLDOFF_TIMEOUT_S = 42;
  localparam logic [31:0] HOLDOFF_CYC = 32'(HOLDOFF_TIMEOUT_S * CLK_HZ);

endpackage

// >>> amrs_top.sv
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/10ps
module amrs_top #(
  parameter logic [31:0] HOLDOFF_CYC = amrs_pkg::HOLDOFF_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Unit address straps
  input wire logic [5:0] i_unit_addr,
  // Decoded bus requests
  input wire logic i_req_valid,
  input wire logic i_req_is_cmd,
  input wire logic [5:0] i_req_addr,
  input wire logic [3:0] i_req_cmd,
  // Acknowledges
  output logic o_ack_valid,
  output logic o_ack_is_cmd,
  output logic [5:0] o_ack_addr,
  output logic [7:0] o_ack_data,
  // Parallel port lines, active low
  output logic [3:0] o_cmd_port_n,
  output logic [7:0] o_mon_port_n,
  // Analog multiplexer and converter
  output logic [2:0] o_adc_chan,
  input wire logic [7:0] i_adc_data,
  // Device monitor inputs
  input wire logic [4:0] i_air_disc_n,
  input wire logic [1:0] i_holdoff_line
);

  typedef struct packed {
    logic [3:0] cmd;
    logic [5:0] unit_addr;
    logic addr_caught;
    logic ack_valid;
    logic ack_is_cmd;
    logic [5:0] ack_addr;
    logic [7:0] ack_data;
    logic [7:0] mon;
    logic [31:0] prdata;
    logic [15:0] req_seen;
    logic [15:0] req_taken;
  } amrs_state_t;

  amrs_state_t st;
  amrs_state_t next_st;

  logic [1:0] holdoff_alarm;
  logic [4:0] air_disc;
  logic [6:0] disc_group;
  logic addr_hit;
  logic addr_match;
  logic apb_setup;
  logic apb_write;
  logic req_ours;
  logic [3:0] cmd_now;

  // One watchdog per serial holdoff line
  amrs_holdoff #(
    .TIMEOUT_CYC(HOLDOFF_CYC)
  ) u_holdoff_0 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_line_active(i_holdoff_line[0]),
    .o_alarm(holdoff_alarm[0])
  );

  amrs_holdoff #(
    .TIMEOUT_CYC(HOLDOFF_CYC)
  ) u_holdoff_1 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_line_active(i_holdoff_line[1]),
    .o_alarm(holdoff_alarm[1])
  );

  // Level discretes arrive active low
  assign air_disc = ~i_air_disc_n;
  assign disc_group = {holdoff_alarm, air_disc};

  assign apb_setup = i_psel && !i_penable;
  assign apb_write = i_psel && i_penable && i_pwrite;

  always_comb
  begin
    unique case (i_paddr)
      amrs_pkg::OFS_CTRL,
      amrs_pkg::OFS_STATUS,
      amrs_pkg::OFS_UNIT,
      amrs_pkg::OFS_COUNT:
      begin
        addr_hit = 1'b1;
      end
      default:
      begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Straps not yet caught never match, so early requests are ignored
  assign addr_match = st.addr_caught && (i_req_addr == st.unit_addr);
  assign req_ours = i_req_valid && addr_match;

  // Command value in force after this cycle's updates
  always_comb
  begin
    cmd_now = st.cmd;
    if (apb_write && (i_paddr == amrs_pkg::OFS_CTRL))
    begin
      cmd_now = i_pwdata[3:0];
    end
    // A command message wins over a local write in the same cycle
    if (req_ours && i_req_is_cmd)
    begin
      cmd_now = i_req_cmd;
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.ack_valid = 1'b0;

    // Straps are caught once, on the first edge after reset release
    if (!st.addr_caught)
    begin
      next_st.unit_addr = {1'b0, i_unit_addr[amrs_pkg::ADDR_USED_W-1:0]};
      next_st.addr_caught = 1'b1;
    end

    // Command ports only steer the readout path
    next_st.cmd = cmd_now;

    if (i_req_valid)
    begin
      next_st.req_seen = 16'(st.req_seen + 16'h0001);
    end

    if (req_ours)
    begin
      next_st.req_taken = 16'(st.req_taken + 16'h0001);
      next_st.ack_valid = 1'b1;
      next_st.ack_is_cmd = i_req_is_cmd;
      next_st.ack_addr = st.unit_addr;
      if (i_req_is_cmd)
      begin
        // Command acknowledge echoes the command for verification
        next_st.ack_data = {4'h0, i_req_cmd};
      end
      else
      begin
        next_st.ack_data = st.mon;
      end
    end

    // Readout multiplexer: analog word or discrete group
    if (st.cmd[amrs_pkg::CTRL_SEL_BIT])
    begin
      next_st.mon = i_adc_data;
    end
    else
    begin
      // Spare eighth channel reads inactive
      next_st.mon = {1'b0, disc_group};
    end

    // Read data is prepared in the setup cycle, held through access
    if (apb_setup)
    begin
      next_st.prdata = 32'h0000_0000;
      unique case (i_paddr)
        amrs_pkg::OFS_CTRL:
        begin
          next_st.prdata[amrs_pkg::CMD_W-1:0] = st.cmd;
        end
        amrs_pkg::OFS_STATUS:
        begin
          next_st.prdata[amrs_pkg::STAT_MON_LSB +: amrs_pkg::MON_W] = st.mon;
          next_st.prdata[amrs_pkg::STAT_DISC_LSB +: amrs_pkg::LEVEL_DISC_W] = air_disc;
          next_st.prdata[amrs_pkg::STAT_ALARM_LSB +: amrs_pkg::HOLDOFF_N] = holdoff_alarm;
          next_st.prdata[amrs_pkg::STAT_SEL_BIT] = st.cmd[amrs_pkg::CTRL_SEL_BIT];
          next_st.prdata[amrs_pkg::STAT_CHAN_LSB +: amrs_pkg::CTRL_CHAN_W] = st.cmd[2:0];
        end
        amrs_pkg::OFS_UNIT:
        begin
          next_st.prdata[amrs_pkg::UNIT_ADDR_LSB +: amrs_pkg::ADDR_W] = st.unit_addr;
          next_st.prdata[amrs_pkg::UNIT_MATCH_BIT] = (st.unit_addr == amrs_pkg::UNIT_ADDR_EXPECT);
          next_st.prdata[amrs_pkg::UNIT_CAUGHT_BIT] = st.addr_caught;
        end
        amrs_pkg::OFS_COUNT:
        begin
          next_st.prdata[amrs_pkg::COUNT_SEEN_LSB +: 16] = st.req_seen;
          next_st.prdata[amrs_pkg::COUNT_TAKEN_LSB +: 16] = st.req_taken;
        end
        default:
        begin
          next_st.prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st.cmd <= amrs_pkg::CTRL_RESET;
      st.unit_addr <= 6'h00;
      st.addr_caught <= 1'b0;
      st.ack_valid <= 1'b0;
      st.ack_is_cmd <= 1'b0;
      st.ack_addr <= 6'h00;
      st.ack_data <= 8'h00;
      st.mon <= 8'h00;
      st.prdata <= 32'h0000_0000;
      st.req_seen <= 16'h0000;
      st.req_taken <= 16'h0000;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_hit;
  assign o_prdata = st.prdata;

  assign o_ack_valid = st.ack_valid;
  assign o_ack_is_cmd = st.ack_is_cmd;
  assign o_ack_addr = st.ack_addr;
  assign o_ack_data = st.ack_data;

  // Port lines leave the block inverted, low meaning one
  assign o_cmd_port_n = ~st.cmd;
  assign o_mon_port_n = ~st.mon;

  // All eight codes pass; only the two populated ones carry sensors
  assign o_adc_chan = st.cmd[amrs_pkg::CTRL_CHAN_LSB +: amrs_pkg::CTRL_CHAN_W];

endmodule // amrs_top

// >>> amrs_top_bench.sv
`timescale 1ns/10ps
module amrs_top_bench;
  localparam logic [31:0] HOLD = 32'h0000_0014;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00, i_adc_data = 8'h00, o_ack_data, o_mon_port_n, b;
  logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, seed = 32'h0000_6332;
  logic [5:0] i_unit_addr = 6'h21, i_req_addr, o_ack_addr;
  logic [4:0] i_air_disc_n = 5'h1F;
  logic [1:0] i_holdoff_line = 2'h3;
  logic [3:0] i_req_cmd, o_cmd_port_n, k;
  logic [2:0] o_adc_chan;
  logic i_req_valid, i_req_is_cmd, o_pready, o_pslverr, o_ack_valid, o_ack_is_cmd;
  logic [31:0] expq[$];
  int miscompares = 0, check_count = 0;
  always #25 i_clk = ~i_clk;
  amrs_top #(.HOLDOFF_CYC(HOLD)) i_amrs_top (.*);
  amrs_pc_model i_amrs_pc_model (.i_clk(i_clk), .o_req_valid(i_req_valid), .o_req_is_cmd(i_req_is_cmd),
    .o_req_addr(i_req_addr), .o_req_cmd(i_req_cmd));
  task check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Reads note the expected word; the monitor compares it
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    if (!w)
      expq.push_back(d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    check(o_pslverr, e);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    // Idle edge so the next call never re-raises psel in the same step
    @(posedge i_clk);
  endtask
  task msg(input logic c, input logic [5:0] a, input logic [3:0] d, input logic [7:0] v);
    if (a == 6'h01)
      expq.push_back({17'h0_0001, c, a, v});
    i_amrs_pc_model.send(c, a, d);
  endtask
  task cmp(input logic [31:0] v);
    if (expq.size() == 0)
      check(32'h0000_0000, 32'h0000_0001);
    else
      check(v, expq.pop_front());
  endtask
  always @(posedge i_clk)
  begin
    if (o_ack_valid === 1'b1)
      cmp({17'h0_0001, o_ack_is_cmd, o_ack_addr, o_ack_data});
    if (i_psel && i_penable && !i_pwrite)
      cmp(o_prdata);
  end
  initial
  begin
    #200_000;
    miscompares++;
    stop_test();
  end
  initial
  begin
    tick(10);
    i_rst_n <= 1'b1;
    tick(4);
    for (int c = 0; c < 16; c++)
    begin
      i_adc_data <= 8'($random(seed));
      i_air_disc_n <= 5'($random(seed));
      apb(1'b1, amrs_pkg::OFS_CTRL, 32'(c), 1'b0);
      tick(3);
      b = c[3] ? i_adc_data : {3'h0, ~i_air_disc_n};
      check(o_cmd_port_n, 4'(~c[3:0]));
      check(o_adc_chan, c[2:0]);
      check(o_mon_port_n, 8'(~b));
      msg(1'b0, 6'h01, 4'h0, b);
      apb(1'b0, amrs_pkg::OFS_CTRL, 32'(c), 1'b0);
    end
    $display("test readout done");
    apb(1'b0, amrs_pkg::OFS_COUNT, 32'h0010_0010, 1'b0);
    apb(1'b1, amrs_pkg::OFS_UNIT, 32'h0000_0000, 1'b0);
    apb(0, amrs_pkg::OFS_UNIT, 32'h0000_0301, 1'b0);
    apb(1'b0, 8'h10, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF, 1'b1);
    $display("test registers done");
    k = 4'($random(seed));
    msg(1'b1, 6'h01, k, {4'h0, k});
    tick(1);
    check(o_cmd_port_n, 4'(~k));
    msg(1'b1, 6'h02, ~k, 8'h00);
    msg(1'b1, 6'h21, ~k, 8'h00);
    tick(2);
    check(o_cmd_port_n, 4'(~k));
    $display("test messages done");
    apb(1'b1, amrs_pkg::OFS_CTRL, 32'h0000_0000, 1'b0);
    i_holdoff_line <= 2'h2;
    tick(16);
    msg(1'b0, 6'h01, 4'h0, {3'h0, ~i_air_disc_n});
    tick(6);
    msg(1'b0, 6'h01, 4'h0, {3'h1, ~i_air_disc_n});
    i_holdoff_line <= 2'h3;
    tick(1);
    i_holdoff_line <= 2'h0;
    tick(16);
    msg(1'b0, 6'h01, 4'h0, {3'h0, ~i_air_disc_n});
    tick(6);
    msg(1'b0, 6'h01, 4'h0, {3'h3, ~i_air_disc_n});
    tick(4);
    check(expq.size(), 32'h0000_0000);
    $display("test holdoff done");
    stop_test();
  end
endmodule // amrs_top_bench

// >>> amrs_top_sva.sv
`timescale 1ns/10ps
module amrs_top_sva #(
  parameter logic [31:0] HOLDOFF_CYC = 32'h0000_0014
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Requests and straps
  input wire logic [5:0] i_unit_addr,
  input wire logic i_req_valid,
  input wire logic i_req_is_cmd,
  input wire logic [5:0] i_req_addr,
  input wire logic [3:0] i_req_cmd,
  // Device inputs
  input wire logic [7:0] i_adc_data,
  input wire logic [4:0] i_air_disc_n,
  input wire logic [1:0] i_holdoff_line,
  // Outputs
  input wire logic o_ack_valid,
  input wire logic o_ack_is_cmd,
  input wire logic [5:0] o_ack_addr,
  input wire logic [7:0] o_ack_data,
  input wire logic [3:0] o_cmd_port_n,
  input wire logic [7:0] o_mon_port_n,
  input wire logic [2:0] o_adc_chan
);
  // Straps settle after release, so early edges are not judged
  logic [1:0] up;
  logic hit;
  assign hit = i_req_valid && i_req_addr == 6'h01 && up == 2'h3;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ack_own_addr_a: assert property (hit |=> o_ack_valid && o_ack_addr == 6'h01)
    else $error("no ack for own address");
  ack_foreign_a: assert property (!hit |=> !o_ack_valid)
    else $error("ack without own request");
  ack_strap_a: assert property (o_ack_valid |-> o_ack_addr == {1'b0, i_unit_addr[4:0]})
    else $error("ack address not strap value");
  ack_cmd_echo_a: assert property (hit && i_req_is_cmd |=> o_ack_is_cmd
    && o_ack_data == {4'h0, $past(i_req_cmd)} && o_cmd_port_n == ~$past(i_req_cmd))
    else $error("command ack or port wrong");
  chan_follow_a: assert property (o_adc_chan == ~o_cmd_port_n[2:0])
    else $error("channel differs from command bits");
  analog_read_a: assert property (up == 2'h3 && !o_cmd_port_n[3] |=> o_mon_port_n == ~$past(i_adc_data))
    else $error("analog word not on monitor port");
  disc_read_a: assert property (up == 2'h3 && o_cmd_port_n[3] |=> o_mon_port_n[7]
    && o_mon_port_n[4:0] == $past(i_air_disc_n))
    else $error("discrete group not on monitor port");
  holdoff_clear_a: assert property (up == 2'h3 && i_holdoff_line[0] ##1 o_cmd_port_n[3] |=> o_mon_port_n[5])
    else $error("holdoff alarm not cleared");
  cover property (hit && i_req_is_cmd);
  cover property (!o_cmd_port_n[3] && o_ack_valid);
  cover property (!o_mon_port_n[5] && o_cmd_port_n[3]);
endmodule // amrs_top_sva
bind amrs_top amrs_top_sva #(.HOLDOFF_CYC(HOLDOFF_CYC)) i_amrs_top_sva (.*);
